// ==== dv/crystal_to_pll_translation_tb.sv ====
// Self-checking testbench for the crystal to PLL translation block
`timescale 1ns/100ps
`default_nettype none

module crystal_to_pll_translation_tb
  import pll_xlate_pkg::*;
;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, seed, osc_khz, pll_khz;
  logic [3:0] wstrb, cur_xs;
  logic awready, wready, bvalid, arready, rvalid, sv;
  logic [1:0] bresp, rresp, ps;
  logic [31:0] rdata;
  logic [8:0] mult;
  logic [4:0] div;
  int errors, check_count, cycles;

  crystal_to_pll_translation i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pll_loop_multiply(mult),
    .pll_input_divide(div), .pll_post_scale(ps), .pll_setting_valid(sv));
  pll_config_model i_pll (.loop_multiply(mult), .input_divide(div), .post_scale(ps), .setting_valid(sv),
    .osc_khz(osc_khz), .out_khz(pll_khz));
  assign osc_khz = CRYSTAL_KHZ[cur_xs];

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] in_band(input logic [31:0] f);
    return {31'h0, (f + PLL_TOLERANCE_KHZ >= PLL_TARGET_KHZ) && (f <= PLL_TARGET_KHZ + PLL_TOLERANCE_KHZ)};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic set_crystal(input logic [31:0] d);
    logic [1:0] r;
    axi_write(RUN_CLOCK_CONFIG_OFFSET, d, 4'hF, r);
    check("write_resp", {30'h0, r}, {30'h0, RESP_OKAY});
    cur_xs = d[3:0];
  endtask

  // Register fields, PLL pins and resulting frequency against the crystal
  task automatic check_crystal(input logic [3:0] xs);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(RUN_CLOCK_CONFIG_OFFSET, d, r);
    check("crystal_select", d, {28'h0, xs});
    axi_read(PLL_TRANSLATION_CONFIG_OFFSET, d, r);
    check("read_resp", {30'h0, r}, {30'h0, RESP_OKAY});
    check("reserved_bits", {16'h0, d[31:16]}, 32'h0);
    check("divide_field", {27'h0, d[4:0]}, {27'h0, div});
    check("multiply_field", {23'h0, d[13:5]}, {23'h0, mult});
    check("post_scale_field", {30'h0, d[15:14]}, {30'h0, ps});
    if (xs >= CRYSTAL_FIRST_SUPPORTED)
    begin
      check("post_scale_legal", {31'h0, d[15:14] != POST_SCALE_RESERVED}, 32'h1);
      check("reg_freq", in_band(osc_khz * (d[13:5] + 32'h2) / (d[4:0] + 32'h2) >> d[15:14]), 32'h1);
      check("pll_freq", in_band(pll_khz), 32'h1);
    end
    else
      check("unsupported", {15'h0, d[15:0], sv}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    {rst, awvalid, wvalid, bready, arvalid, rready} <= 6'h20;
    {awaddr, araddr, wdata, wstrb} <= '0;
    cur_xs = CRYSTAL_SELECT_RESET;
    seed = 32'h0000F55A;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check_crystal(CRYSTAL_SELECT_RESET);
    $display("test reset_load done");
    for (int i = 0; i < 16; i++)
    begin
      set_crystal(i);
      check_crystal(i[3:0]);
    end
    $display("test sweep done");
    repeat (24)
    begin
      seed = xorshift(seed);
      set_crystal(seed);
      check_crystal(seed[3:0]);
    end
    $display("test random done");
    seed = xorshift(seed);
    axi_write(PLL_TRANSLATION_CONFIG_OFFSET, seed, 4'hF, r);
    check("ro_write_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(12'h100, seed, 4'hF, r);
    check("unmapped_write_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_write(RUN_CLOCK_CONFIG_OFFSET, {seed[31:4], cur_xs + 4'h1}, 4'hE, r);
    check("lane_write_resp", {30'h0, r}, {30'h0, RESP_OKAY});
    check_crystal(cur_xs);
    axi_read(12'h100, d, r);
    check("unmapped_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped_data", d, 32'h0);
    $display("test refusals done");
    set_crystal(32'h7);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cur_xs = CRYSTAL_SELECT_RESET;
    check_crystal(CRYSTAL_SELECT_RESET);
    $display("test second_reset done");
    test_done();
  end
endmodule // crystal_to_pll_translation_tb

`default_nettype wire

// ==== dv/pll_config_model.sv ====
// Behavioural model of the PLL configuration inputs
`timescale 1ns/100ps
`default_nettype none

module pll_config_model
(
  // Settings from the translation block
  input wire logic [8:0] loop_multiply,
  input wire logic [4:0] input_divide,
  input wire logic [1:0] post_scale,
  input wire logic setting_valid,
  // Reference in and resulting frequency out, in kHz
  input wire logic [31:0] osc_khz,
  output logic [31:0] out_khz
);
  logic [31:0] vco_khz;

  // No lock time is modelled, so the result follows the settings at once
  always_comb
  begin
    vco_khz = osc_khz * ({23'h0, loop_multiply} + 32'h2) / ({27'h0, input_divide} + 32'h2);
    case (post_scale)
      2'h0: out_khz = vco_khz;
      2'h1: out_khz = vco_khz >> 1;
      2'h2: out_khz = vco_khz >> 2;
      default: out_khz = 32'h0;
    endcase
    if (setting_valid !== 1'b1)
    begin
      out_khz = 32'h0;
    end
  end
endmodule // pll_config_model

`default_nettype wire

// ==== hdl/crystal_to_pll_translation.sv ====
// Module: crystal to PLL translation with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none

module crystal_to_pll_translation
  import pll_xlate_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // PLL configuration inputs
  output logic [8:0] pll_loop_multiply,
  output logic [4:0] pll_input_divide,
  output logic [1:0] pll_post_scale,
  output logic pll_setting_valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_state_t state;
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [3:0] crystal_select;
    logic [8:0] loop_multiply;
    logic [4:0] input_divide;
    logic [1:0] post_scale;
    logic supported;
    logic loaded;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rd_xlate;
  } regs_t;

  regs_t r;
  regs_t next_r;

  logic [8:0] lk_multiply;
  logic [4:0] lk_divide;
  logic [1:0] lk_post_scale;
  logic lk_supported;
  logic [31:0] xlate_word;
  logic [31:0] config_word;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_hit_config;
  logic wr_hit_xlate;
  logic rd_hit_config;
  logic rd_hit_xlate;

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  pll_setting_lookup u_lookup (
    .crystal_select(r.crystal_select),
    .loop_multiply(lk_multiply),
    .input_divide(lk_divide),
    .post_scale(lk_post_scale),
    .supported(lk_supported)
  );

  // ----------------------------------------------------------------
  // Register words and decode
  // ----------------------------------------------------------------
  always_comb
  begin
    xlate_word = '0;
    xlate_word[DIVIDE_LSB +: DIVIDE_W] = r.input_divide;
    xlate_word[MULTIPLY_LSB +: MULTIPLY_W] = r.loop_multiply;
    xlate_word[POST_SCALE_LSB +: POST_SCALE_W] = r.post_scale;
    config_word = '0;
    config_word[CRYSTAL_LSB +: CRYSTAL_W] = r.crystal_select;
  end

  assign wr_hit_config = (r.aw_addr[AXI_ADDR_W-1:2] == RUN_CLOCK_CONFIG_OFFSET[AXI_ADDR_W-1:2]);
  assign wr_hit_xlate = (r.aw_addr[AXI_ADDR_W-1:2] == PLL_TRANSLATION_CONFIG_OFFSET[AXI_ADDR_W-1:2]);
  assign rd_hit_config = (s_axi_araddr[AXI_ADDR_W-1:2] == RUN_CLOCK_CONFIG_OFFSET[AXI_ADDR_W-1:2]);
  assign rd_hit_xlate = (s_axi_araddr[AXI_ADDR_W-1:2] == PLL_TRANSLATION_CONFIG_OFFSET[AXI_ADDR_W-1:2]);

  // Nothing is accepted while the reset load is running, so no read sees a stale word
  assign s_axi_awready = (r.state == ST_IDLE) && !r.aw_got;
  assign s_axi_wready = (r.state == ST_IDLE) && !r.w_got;
  // Writes go first; a read waits until no write half is pending
  assign s_axi_arready = (r.state == ST_IDLE) && !r.aw_got && !r.w_got && !s_axi_awvalid && !s_axi_wvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    // Settings follow the crystal field every cycle, so any change lands one cycle later
    next_r.loop_multiply = lk_multiply;
    next_r.input_divide = lk_divide;
    next_r.post_scale = lk_post_scale;
    next_r.supported = lk_supported;
    case (r.state)
      ST_LOAD:
      begin
        next_r.loaded = 1'b1;
        next_r.state = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (aw_take)
        begin
          next_r.aw_got = 1'b1;
          next_r.aw_addr = s_axi_awaddr;
        end
        if (w_take)
        begin
          next_r.w_got = 1'b1;
          next_r.w_data = s_axi_wdata;
          next_r.w_strb = s_axi_wstrb;
        end
        if (r.aw_got && r.w_got)
        begin
          next_r.aw_got = 1'b0;
          next_r.w_got = 1'b0;
          next_r.state = ST_WRESP;
          if (wr_hit_config)
          begin
            next_r.bresp = RESP_OKAY;
            if (r.w_strb[0])
            begin
              next_r.crystal_select = r.w_data[CRYSTAL_LSB +: CRYSTAL_W];
            end
          end
          else
          begin
            // Translation word is read-only and holes are unmapped
            next_r.bresp = RESP_SLVERR;
          end
        end
        else if (ar_take)
        begin
          next_r.state = ST_RRESP;
          next_r.rd_xlate = rd_hit_xlate;
          if (rd_hit_xlate)
          begin
            next_r.rdata = xlate_word;
            next_r.rresp = RESP_OKAY;
          end
          else if (rd_hit_config)
          begin
            next_r.rdata = config_word;
            next_r.rresp = RESP_OKAY;
          end
          else
          begin
            next_r.rdata = '0;
            next_r.rresp = RESP_SLVERR;
          end
        end
      end
      ST_WRESP:
      begin
        if (s_axi_bready)
        begin
          next_r.state = ST_IDLE;
        end
      end
      ST_RRESP:
      begin
        if (s_axi_rready)
        begin
          next_r.state = ST_IDLE;
        end
      end
      default:
      begin
        next_r.state = ST_LOAD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.state <= ST_LOAD;
      r.crystal_select <= CRYSTAL_SELECT_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = (r.state == ST_WRESP);
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = (r.state == ST_RRESP);
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  // The PLL sees exactly the register fields, so software reads what the PLL gets
  assign pll_loop_multiply = r.loop_multiply;
  assign pll_input_divide = r.input_divide;
  assign pll_post_scale = r.post_scale;
  assign pll_setting_valid = r.loaded && r.supported;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_setting_matches_crystal;
    @(posedge clk) disable iff (rst)
    r.loaded |-> (pll_loop_multiply == MULTIPLY_TABLE[$past(r.crystal_select)])
      && (pll_input_divide == DIVIDE_TABLE[$past(r.crystal_select)]);
  endproperty
  a_setting_matches_crystal: assert property (p_setting_matches_crystal)
    else $error("PLL settings do not match the selected crystal");

  property p_loaded_before_access;
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> !s_axi_arready ##1 r.loaded;
  endproperty
  a_loaded_before_access: assert property (p_loaded_before_access)
    else $error("Translation register not loaded before bus access");

  property p_update_on_crystal_change;
    @(posedge clk) disable iff (rst)
    (r.crystal_select != $past(r.crystal_select)) |=>
      (r.loop_multiply == MULTIPLY_TABLE[$past(r.crystal_select)])
      && (r.input_divide == DIVIDE_TABLE[$past(r.crystal_select)]);
  endproperty
  a_update_on_crystal_change: assert property (p_update_on_crystal_change)
    else $error("Translation not updated after crystal change");

  // Settings lag the crystal field by one cycle, so the crystal is taken from the cycle before
  property p_frequency_in_range;
    @(posedge clk) disable iff (rst)
    pll_setting_valid |->
      ((CRYSTAL_KHZ[$past(r.crystal_select)] * (32'(pll_loop_multiply) + FORMULA_OFFSET)
        / (32'(pll_input_divide) + FORMULA_OFFSET)) + PLL_TOLERANCE_KHZ > PLL_TARGET_KHZ)
      && ((CRYSTAL_KHZ[$past(r.crystal_select)] * (32'(pll_loop_multiply) + FORMULA_OFFSET)
        / (32'(pll_input_divide) + FORMULA_OFFSET)) < PLL_TARGET_KHZ + PLL_TOLERANCE_KHZ);
  endproperty
  a_frequency_in_range: assert property (p_frequency_in_range)
    else $error("PLL frequency from the settings is off target");

  property p_divide_readback;
    @(posedge clk) disable iff (rst)
    (s_axi_rvalid && r.rd_xlate) |-> (s_axi_rdata[4:0] == pll_input_divide);
  endproperty
  a_divide_readback: assert property (p_divide_readback)
    else $error("Read divide value differs from the PLL input");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
    (s_axi_rvalid && r.rd_xlate) |-> (s_axi_rdata[31:16] == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved translation bits read nonzero");

  property p_fields_readback;
    @(posedge clk) disable iff (rst)
    (s_axi_rvalid && r.rd_xlate) |-> (s_axi_rdata[13:5] == pll_loop_multiply)
      && (s_axi_rdata[15:14] == pll_post_scale) && (pll_post_scale != POST_SCALE_RESERVED);
  endproperty
  a_fields_readback: assert property (p_fields_readback)
    else $error("Multiply or post-scale field misplaced");

  property p_xlate_write_refused;
    @(posedge clk) disable iff (rst)
    ((r.state == ST_IDLE) && r.aw_got && r.w_got && wr_hit_xlate) |=>
      s_axi_bvalid && (s_axi_bresp == RESP_SLVERR) && $stable(r.crystal_select);
  endproperty
  a_xlate_write_refused: assert property (p_xlate_write_refused)
    else $error("Write to read-only translation register not refused");

endmodule // crystal_to_pll_translation

`default_nettype wire

// ==== hdl/pll_setting_lookup.sv ====
// Module: combinational crystal to PLL setting lookup
`timescale 1ns/100ps
`default_nettype none

module pll_setting_lookup
  import pll_xlate_pkg::*;
(
  // Crystal choice
  input wire logic [3:0] crystal_select,
  // PLL settings
  output logic [8:0] loop_multiply,
  output logic [4:0] input_divide,
  output logic [1:0] post_scale,
  output logic supported
);

  // ----------------------------------------------------------------
  // Table lookup
  // ----------------------------------------------------------------
  // Low crystals cannot reach the PLL range, so they get all-zero settings
  always_comb
  begin
    loop_multiply = MULTIPLY_TABLE[crystal_select];
    input_divide = DIVIDE_TABLE[crystal_select];
    post_scale = POST_SCALE_DIV1;
    supported = (crystal_select >= CRYSTAL_FIRST_SUPPORTED);
  end

endmodule // pll_setting_lookup

`default_nettype wire

// ==== hdl/pll_xlate_pkg.sv ====
// Package: constants, register map and lookup tables for the crystal to PLL translation block
//
// Overview of operation
// - The PLL settings are derived from the selected crystal frequency, one set of settings per crystal choice.
// - The translation register is loaded during the reset sequence, before software can read it.
// - A change of the crystal_select field in run_clock_config recomputes and updates the translation register.
// - The PLL frequency is the oscillator frequency times (loop_multiply_input + 2) over (input_divide_value + 2).
// - Bits 4:0 hold input_divide_value, the same value that drives the PLL input-divide input.
// - Bits 31:16 of the translation register are reserved, read-only and read as zero.
package pll_xlate_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned AXI_ADDR_W = 12;
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFFSET = 12'h070;
  localparam logic [11:0] PLL_TRANSLATION_CONFIG_OFFSET = 12'h064;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int unsigned CRYSTAL_LSB = 0;
  localparam int unsigned CRYSTAL_W = 4;
  localparam logic [3:0] CRYSTAL_SELECT_RESET = 4'hB;
  localparam logic [3:0] CRYSTAL_FIRST_SUPPORTED = 4'h4;
  localparam int unsigned DIVIDE_LSB = 0;
  localparam int unsigned DIVIDE_W = 5;
  localparam int unsigned MULTIPLY_LSB = 5;
  localparam int unsigned MULTIPLY_W = 9;
  localparam int unsigned POST_SCALE_LSB = 14;
  localparam int unsigned POST_SCALE_W = 2;
  localparam int unsigned RESERVED_LSB = 16;
  localparam logic [1:0] POST_SCALE_DIV1 = 2'h0;
  localparam logic [1:0] POST_SCALE_DIV2 = 2'h1;
  localparam logic [1:0] POST_SCALE_DIV4 = 2'h2;
  localparam logic [1:0] POST_SCALE_RESERVED = 2'h3;
  localparam int unsigned FORMULA_OFFSET = 2;

  // ----------------------------------------------------------------
  // Translation tables, indexed by crystal_select
  // ----------------------------------------------------------------
  localparam int unsigned PLL_TARGET_KHZ = 400000;
  localparam int unsigned PLL_TOLERANCE_KHZ = 2000;
  localparam int unsigned CRYSTAL_KHZ [16] = '{1000, 1843, 2000, 2458, 3580, 3686, 4000, 4096,
                                               4915, 5000, 5120, 6000, 6144, 7373, 8000, 8192};
  localparam logic [8:0] MULTIPLY_TABLE [16] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h0DE, 9'h0D7, 9'h0C6, 9'h0C1,
                                                 9'h0A1, 9'h09E, 9'h09A, 9'h083, 9'h080, 9'h06B, 9'h062, 9'h060};
  localparam logic [4:0] DIVIDE_TABLE [16] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00,
                                               5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_WRESP, ST_RRESP} bus_state_t;

endpackage
